// [include/gwp_params.svh]
// constants for the frame-memory window write port
// assumes inclusion by both link ends and the bench
`ifndef GWP_PARAMS_SVH
`define GWP_PARAMS_SVH

// ---------------------------------------------------------------
// link command codes
// ---------------------------------------------------------------
`define GWP_COL_START_HI 16'h2A00
`define GWP_COL_START_LO 16'h2A01
`define GWP_COL_END_HI 16'h2A02
`define GWP_COL_END_LO 16'h2A03
`define GWP_ROW_START_HI 16'h2B00
`define GWP_ROW_START_LO 16'h2B01
`define GWP_ROW_END_HI 16'h2B02
`define GWP_ROW_END_LO 16'h2B03
`define GWP_MEM_WRITE 16'h2C00

// ---------------------------------------------------------------
// resolution select codes and line limits
// ---------------------------------------------------------------
`define GWP_RES_864 8'h70
`define GWP_RES_854 8'h6B
`define GWP_RES_800 8'h50
`define GWP_RES_720 8'h28
`define GWP_RES_640 8'h00
`define GWP_LIM_864 16'h035F
`define GWP_LIM_854 16'h0355
`define GWP_LIM_800 16'h031F
`define GWP_LIM_720 16'h02CF
`define GWP_LIM_640 16'h027F
`define GWP_LIM_WIDTH 16'h01DF

// ---------------------------------------------------------------
// window reset values
// ---------------------------------------------------------------
`define GWP_COL_START_RST 16'h0000
`define GWP_COL_END_RST 16'h01DF
`define GWP_ROW_START_RST 16'h0000
`define GWP_ROW_END_RST 16'h035F

// ---------------------------------------------------------------
// host register offsets (APB byte addresses)
// ---------------------------------------------------------------
`define GWP_REG_CMD 12'h000
`define GWP_REG_PIXEL 12'h004
`define GWP_REG_COUNT 12'h008
`define GWP_CMD_BYTE_LSB 16

`endif

// [include/gwp_pkg.sv]
// types shared by both ends of the window write port
// assumes no other package
package gwp_pkg;
  typedef logic [15:0] gwp_coord_t;
  typedef logic [23:0] gwp_pixel_t;
  typedef enum logic {GWP_IDLE, GWP_STREAM} gwp_wstate_t;
endpackage : gwp_pkg

// [include/gwp_link_if.sv]
// link between host controller and display driver end
// assumes both ends share pclk; strobe is a one-cycle pulse
`timescale 1ns/1ps
interface gwp_link_if;
  logic strobe;
  logic param;
  logic [15:0] addr;
  gwp_pkg::gwp_pixel_t data;

  modport host (output strobe, output param, output addr, output data);
  modport device (input strobe, input param, input addr, input data);
endinterface : gwp_link_if

// [design/gwp_device.sv]
// display driver end: window registers, pixel write path to frame memory
// assumes the link and configuration inputs run on pclk; memory is external
//
// Functional notes
// - host keeps column start not above end
// - host keeps row start not above end
// - out-of-range columns drop their pixels
// - out-of-range rows drop their pixels
// - select 70h: column limit 479 or 863
// - exchange set: column limit is lines minus one
// - select 70h: row limit 863 or 479
// - exchange clear: row limit is lines minus one
// - row window bytes at 2B00h to 2B03h
// - window commands touch only the window and end any stream
// - memory write command 2C00h streams pixels
// - memory write reloads counters to start
// - each pixel stored, counters then advance
// - any other command ends the stream
// - pixel count per stream is unlimited
// - sleep-in blocks frame memory writes
// - commands accepted in every mode, sleep too
// - frame memory contents undefined after reset
// - column window bytes at 2A00h to 2A03h
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "gwp_params.svh"

module gwp_device #(
  parameter int CW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  gwp_link_if.device link,
  input wire logic [7:0] resolution_select,
  input wire logic row_column_exchange,
  input wire logic mirror_x,
  input wire logic mirror_y,
  input wire logic sleep_in,
  output logic mem_we,
  output gwp_pkg::gwp_coord_t mem_col,
  output gwp_pkg::gwp_coord_t mem_row,
  output gwp_pkg::gwp_pixel_t mem_data,
  output logic streaming,
  output gwp_pkg::gwp_coord_t col_start,
  output gwp_pkg::gwp_coord_t col_end,
  output gwp_pkg::gwp_coord_t row_start,
  output gwp_pkg::gwp_coord_t row_end
);

  // ---------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------
  function automatic gwp_pkg::gwp_coord_t line_limit(input logic [7:0] sel);
    case (sel)
      `GWP_RES_864: line_limit = `GWP_LIM_864;
      `GWP_RES_854: line_limit = `GWP_LIM_854;
      `GWP_RES_800: line_limit = `GWP_LIM_800;
      `GWP_RES_720: line_limit = `GWP_LIM_720;
      `GWP_RES_640: line_limit = `GWP_LIM_640;
      // unknown codes get the largest panel
      default: line_limit = `GWP_LIM_864;
    endcase
  endfunction : line_limit

  function automatic gwp_pkg::gwp_coord_t step(input gwp_pkg::gwp_coord_t v,
                                               input logic down);
    step = down ? v - 16'h0001 : v + 16'h0001;
  endfunction : step

  gwp_pkg::gwp_wstate_t wstate;
  gwp_pkg::gwp_coord_t cur_col;
  gwp_pkg::gwp_coord_t cur_row;
  gwp_pkg::gwp_coord_t col_limit;
  gwp_pkg::gwp_coord_t row_limit;
  gwp_pkg::gwp_coord_t first_col;
  gwp_pkg::gwp_coord_t last_col;
  gwp_pkg::gwp_coord_t first_row;
  gwp_pkg::gwp_coord_t last_row;
  logic cmd_take;
  logic px_take;
  logic in_range;

  // ---------------------------------------------------------------
  // limits and start positions
  // ---------------------------------------------------------------
  always_comb begin
    col_limit = row_column_exchange ? line_limit(resolution_select) : `GWP_LIM_WIDTH;
    row_limit = row_column_exchange ? `GWP_LIM_WIDTH : line_limit(resolution_select);
  end

  assign first_col = mirror_x ? col_end : col_start;
  assign last_col = mirror_x ? col_start : col_end;
  assign first_row = mirror_y ? row_end : row_start;
  assign last_row = mirror_y ? row_start : row_end;

  assign cmd_take = link.strobe && !link.param;
  // any number of pixels while streaming
  assign px_take = link.strobe && link.param && (wstate == gwp_pkg::GWP_STREAM);
  assign in_range = (cur_col <= col_limit) && (cur_row <= row_limit);
  assign streaming = (wstate == gwp_pkg::GWP_STREAM);

  // ---------------------------------------------------------------
  // window registers
  // ---------------------------------------------------------------
  // only window bytes change the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_start <= `GWP_COL_START_RST;
      col_end <= `GWP_COL_END_RST;
      row_start <= `GWP_ROW_START_RST;
      row_end <= `GWP_ROW_END_RST;
    end else if (cmd_take) begin
      case (link.addr)
        `GWP_COL_START_HI: col_start[15:8] <= link.data[7:0];
        `GWP_COL_START_LO: col_start[7:0] <= link.data[7:0];
        `GWP_COL_END_HI: col_end[15:8] <= link.data[7:0];
        `GWP_COL_END_LO: col_end[7:0] <= link.data[7:0];
        `GWP_ROW_START_HI: row_start[15:8] <= link.data[7:0];
        `GWP_ROW_START_LO: row_start[7:0] <= link.data[7:0];
        `GWP_ROW_END_HI: row_end[15:8] <= link.data[7:0];
        `GWP_ROW_END_LO: row_end[7:0] <= link.data[7:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // stream state
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wstate <= gwp_pkg::GWP_IDLE;
    end else if (cmd_take) begin
      wstate <= (link.addr == `GWP_MEM_WRITE) ? gwp_pkg::GWP_STREAM : gwp_pkg::GWP_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // address counters
  // ---------------------------------------------------------------
  // counters are private to the stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_col <= `GWP_COL_START_RST;
      cur_row <= `GWP_ROW_START_RST;
    end else if (cmd_take && link.addr == `GWP_MEM_WRITE) begin
      cur_col <= first_col;
      cur_row <= first_row;
    end else if (px_take) begin
      // advance after every pixel
      // dropped pixels still advance so the image stays aligned
      if (cur_col == last_col) begin
        cur_col <= first_col;
        cur_row <= (cur_row == last_row) ? first_row : step(cur_row, mirror_y);
      end else begin
        cur_col <= step(cur_col, mirror_x);
      end
    end
  end

  // ---------------------------------------------------------------
  // frame memory write port
  // ---------------------------------------------------------------
  // memory itself is outside; no init is attempted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_we <= 1'b0;
      mem_col <= 16'h0000;
      mem_row <= 16'h0000;
      mem_data <= 24'h000000;
    end else begin
      // sleep or range drops the write
      mem_we <= px_take && in_range && !sleep_in;
      if (px_take) begin
        mem_col <= cur_col;
        mem_row <= cur_row;
        mem_data <= link.data;
      end
    end
  end

endmodule : gwp_device

// [design/gwp_host.sv]
// host controller end: APB registers turned into link commands and pixels
// assumes software keeps window start not above end
`timescale 1ns/1ps
`include "gwp_params.svh"

module gwp_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  gwp_link_if.host link
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [23:0] last_cmd;
  logic [15:0] sent_count;
  logic mapped;
  logic wr_acc;

  assign mapped = (paddr == `GWP_REG_CMD) || (paddr == `GWP_REG_PIXEL) ||
                  (paddr == `GWP_REG_COUNT);
  // zero-wait slave: every access phase completes at once
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc = psel && penable && pwrite && mapped;

  // ---------------------------------------------------------------
  // link drive
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.strobe <= 1'b0;
      link.param <= 1'b0;
      link.addr <= 16'h0000;
      link.data <= 24'h000000;
    end else begin
      link.strobe <= wr_acc && (paddr != `GWP_REG_COUNT);
      if (wr_acc && paddr == `GWP_REG_CMD) begin
        link.param <= 1'b0;
        link.addr <= pwdata[15:0];
        link.data <= {16'h0000, pwdata[`GWP_CMD_BYTE_LSB +: 8]};
      end else if (wr_acc && paddr == `GWP_REG_PIXEL) begin
        link.param <= 1'b1;
        link.addr <= `GWP_MEM_WRITE;
        link.data <= pwdata[23:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // status registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cmd <= 24'h000000;
      sent_count <= 16'h0000;
    end else begin
      if (wr_acc && paddr == `GWP_REG_CMD) begin
        last_cmd <= pwdata[23:0];
      end
      if (wr_acc && paddr == `GWP_REG_PIXEL) begin
        sent_count <= sent_count + 16'h0001;
      end else if (wr_acc && paddr == `GWP_REG_COUNT) begin
        sent_count <= 16'h0000;
      end
    end
  end

  // read data latched in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `GWP_REG_CMD: prdata <= {8'h00, last_cmd};
        `GWP_REG_COUNT: prdata <= {16'h0000, sent_count};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule : gwp_host

// [tb/gwp_link_checker.sv]
// concurrent checks on the link and the driver-end outputs
// assumes instantiation beside the link interface, one pclk domain
`timescale 1ns/1ps
`include "gwp_params.svh"
module gwp_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic strobe,
  input wire logic param,
  input wire logic [15:0] addr,
  input wire gwp_pkg::gwp_pixel_t data,
  input wire logic sleep_in,
  input wire logic mem_we,
  input wire gwp_pkg::gwp_pixel_t mem_data,
  input wire logic streaming,
  input wire gwp_pkg::gwp_coord_t col_start,
  input wire gwp_pkg::gwp_coord_t row_start,
  input wire gwp_pkg::gwp_coord_t row_end
);
  // ------------------------------------------------------------
  // link properties
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cmd(logic [15:0] c);
    strobe && !param && addr == c;
  endsequence
  sequence s_pix;
    strobe && param;
  endsequence
  property p_enter; s_cmd(`GWP_MEM_WRITE) |=> streaming; endproperty
  a_enter: assert property (p_enter) else $error("stream not entered");
  property p_leave; strobe && !param && addr != `GWP_MEM_WRITE |=> !streaming; endproperty
  a_leave: assert property (p_leave) else $error("stream not ended");
  property p_src; mem_we |-> $past(strobe && param && streaming && !sleep_in); endproperty
  a_src: assert property (p_src) else $error("write without pixel");
  property p_data; mem_we |-> mem_data == $past(data); endproperty
  a_data: assert property (p_data) else $error("pixel data changed");
  property p_sleep; s_pix ##0 sleep_in |=> !mem_we; endproperty
  a_sleep: assert property (p_sleep) else $error("write in sleep");
  property p_keep; s_cmd(`GWP_MEM_WRITE) |=> $stable(col_start) && $stable(row_end); endproperty
  a_keep: assert property (p_keep) else $error("window moved by write");
  property p_col; s_cmd(`GWP_COL_START_LO) |=> col_start[7:0] == $past(data[7:0]); endproperty
  a_col: assert property (p_col) else $error("column start low byte");
  property p_row; s_cmd(`GWP_ROW_START_HI) |=> row_start[15:8] == $past(data[7:0]); endproperty
  a_row: assert property (p_row) else $error("row start high byte");
  property p_iso; strobe && !param && addr[15:8] == 8'h2A |=> $stable(row_end); endproperty
  a_iso: assert property (p_iso) else $error("row window disturbed");
endmodule : gwp_link_checker

// [tb/tb.sv]
// bench: host and driver ends joined by the link, queue model of frame writes
// assumes pready answers by itself; window changes only between streams
`timescale 1ns/1ps
`include "gwp_params.svh"
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ex, mx, my, slp, mem_we, streaming;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0] res;
  logic erv;
  logic [55:0] ew;
  gwp_pkg::gwp_coord_t mem_col, mem_row, cs_o, ce_o, rs_o, re_o;
  gwp_pkg::gwp_pixel_t mem_data;
  int n_fail, n_tests, cs, ce, rs, re, mc, mr, n_px;
  bit strm;
  logic [55:0] q[$];
  logic [7:0] codes[5] = '{8'h70, 8'h6B, 8'h50, 8'h28, 8'h00};
  gwp_link_if link();
  gwp_host i_gwp_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  gwp_device i_gwp_device (.pclk(pclk), .presetn(presetn), .link(link), .resolution_select(res),
    .row_column_exchange(ex), .mirror_x(mx), .mirror_y(my), .sleep_in(slp), .mem_we(mem_we),
    .mem_col(mem_col), .mem_row(mem_row), .mem_data(mem_data), .streaming(streaming),
    .col_start(cs_o), .col_end(ce_o), .row_start(rs_o), .row_end(re_o));
  gwp_link_checker i_gwp_link_checker (.pclk(pclk), .presetn(presetn), .strobe(link.strobe),
    .param(link.param), .addr(link.addr), .data(link.data), .sleep_in(slp), .mem_we(mem_we),
    .mem_data(mem_data), .streaming(streaming), .col_start(cs_o), .row_start(rs_o),
    .row_end(re_o));
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // shared tasks and model
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    k = 0;
    while (pready !== 1'b1) begin
      if (++k > 50) begin n_fail++; finish_test(); end
      @(posedge pclk);
    end
    rdv = prdata; erv = pslverr; psel <= 0; penable <= 0;
  endtask : apb
  function int llim(logic [7:0] r);
    case (r)
      8'h6B: return 853;
      8'h50: return 799;
      8'h28: return 719;
      8'h00: return 639;
      default: return 863;
    endcase
  endfunction : llim
  task cmd(input logic [15:0] c, input logic [7:0] b);
    apb(`GWP_REG_CMD, 1, {8'h00, b, c});
    strm = (c == `GWP_MEM_WRITE);
    mc = mx ? ce : cs;
    mr = my ? re : rs;
  endtask : cmd
  // callers keep start not above end
  task win(input int c0, input int c1, input int r0, input int r1);
    cs = c0; ce = c1; rs = r0; re = r1;
    cmd(`GWP_COL_START_HI, c0[15:8]); cmd(`GWP_COL_START_LO, c0[7:0]);
    cmd(`GWP_COL_END_HI, c1[15:8]); cmd(`GWP_COL_END_LO, c1[7:0]);
    cmd(`GWP_ROW_START_HI, r0[15:8]); cmd(`GWP_ROW_START_LO, r0[7:0]);
    cmd(`GWP_ROW_END_HI, r1[15:8]); cmd(`GWP_ROW_END_LO, r1[7:0]);
    repeat (3) @(posedge pclk);
    chk("col window", {cs_o, ce_o}, {c0[15:0], c1[15:0]});
    chk("row window", {rs_o, re_o}, {r0[15:0], r1[15:0]});
  endtask : win
  task pix(input int n);
    logic [23:0] p;
    bit st;
    repeat (n) begin
      p = 24'($urandom);
      apb(`GWP_REG_PIXEL, 1, {8'h00, p});
      n_px++;
      if (strm) begin
        // dropped outside the limits or asleep, position still moves
        if (mc <= (ex ? llim(res) : 479) && mr <= (ex ? 479 : llim(res)) && !slp)
          q.push_back({mc[15:0], mr[15:0], p});
        st = mx ? (mc == cs) : (mc == ce);
        mc = st ? (mx ? ce : cs) : (mx ? mc - 1 : mc + 1);
        if (st) mr = my ? ((mr == rs) ? re : mr - 1) : ((mr == re) ? rs : mr + 1);
      end
    end
  endtask : pix
  task start;
    cmd(`GWP_MEM_WRITE, 8'h00);
    repeat (3) @(posedge pclk);
    chk("streaming", streaming, 1);
  endtask : start
  always @(posedge pclk) begin
    if (mem_we === 1'b1) begin
      if (q.size() == 0) chk("spurious write", 1, 0);
      else begin
        ew = q.pop_front();
        chk("write position", {mem_col, mem_row}, ew[55:24]);
        chk("write data", mem_data, ew[23:0]);
      end
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, ex, mx, my, slp, paddr, pwdata, res} = '0;
    void'($urandom(13));
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    chk("reset col window", {cs_o, ce_o}, 32'h0000_01DF);
    chk("reset row window", {rs_o, re_o}, 32'h0000_035F);
    $display("test reset done");
    win(10, 13, 5, 7);
    start();
    apb(`GWP_REG_CMD, 0, 0);
    chk("cmd readback", rdv, 32'h0000_2C00);
    pix(15);
    $display("test wrap done");
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      res <= codes[i % 5];
      ex <= (i >= 5);
      @(posedge pclk);
      // window straddles both limits in either exchange setting
      if (ex) win(llim(res) - 1, llim(res) + 1, 478, 480);
      else win(478, 480, llim(res) - 1, llim(res) + 1);
      start();
      pix(9);
    end
    $display("test limits done");
    @(posedge pclk);
    {res, ex, mx, my, slp} <= {8'h70, 4'b0111};
    win(0, 2, 0, 1);
    start();
    pix(3);
    @(posedge pclk);
    slp <= 0;
    pix(7);
    $display("test mirror and sleep done");
    cmd(16'h2900, 8'h00);
    repeat (3) @(posedge pclk);
    chk("stream ended", streaming, 0);
    pix(2);
    apb(12'h0FC, 1, 32'h0);
    chk("unmapped error", erv, 1);
    apb(`GWP_REG_COUNT, 0, 0);
    chk("pixel count", rdv, n_px);
    apb(`GWP_REG_COUNT, 1, 0);
    apb(`GWP_REG_COUNT, 0, 0);
    chk("count cleared", rdv, 0);
    repeat (5) @(posedge pclk);
    chk("writes missing", q.size(), 0);
    $display("test stop done");
    finish_test();
  end
  initial begin
    #3000000;
    n_fail++;
    finish_test();
  end
endmodule : tb
